// file: include/servo_param_cfg.svh
`ifndef SERVO_PARAM_CFG_SVH
`define SERVO_PARAM_CFG_SVH

// ****************************************************************
// Reset values.
// ****************************************************************
`define MON_SEL_RESET 4'h0
`define MON_RANGE_RESET 32'sd10000
`define MON_OFFSET_RESET 32'sd0
`define PROX_RESET 32'h0
`define NOTCH_FREQ_RESET 16'h0
`define NOTCH_Q_RESET 16'd25
`define SEQ_OPT_RESET 2'h0
`define HOME_MODE_RESET 3'h6
`define STOP_DECEL_RESET 16'h0

// ****************************************************************
// Accepted spans of the parameter values, and the monitor's automatic range and offset.
// ****************************************************************
`define MON_SEL_MAX 32'd8
`define MON_RANGE_AUTO 32'sd10000
`define MON_OFFSET_AUTO 32'sd0
`define MON_RANGE_MIN 32'sd1
`define MON_RANGE_MAX 32'sd100000
`define MON_OFFSET_LIMIT 32'sd32767
`define PROX_MAX 32'd262144000
`define NOTCH_FREQ_MIN 32'd40
`define NOTCH_FREQ_MAX 32'd1000
`define NOTCH_Q_MIN 32'd10
`define NOTCH_Q_MAX 32'd500
`define SEQ_OPT_MAX 32'd2
`define STOP_DECEL_MAX 32'd8000

// ****************************************************************
// Bus voltage scaling, in tenths of a volt.
// ****************************************************************
`define DC_FULL_SCALE 13'd4013
`define DC_RAW_SHIFT 12

// ****************************************************************
// Home return mode codes.
// ****************************************************************
`define HOME_LEAVE 3'h1
`define HOME_LEAVE_Z 3'h3
`define HOME_ENTER_Z 3'h4
`define HOME_ENTER 3'h5
`define HOME_HERE 3'h6
`define HOME_LIMIT_Z 3'h7

`endif

// file: include/servo_param_pkg.sv
package servo_param_pkg;

   typedef enum logic [3:0] {
      P_MON_SEL = 4'h0,
      P_MON_RANGE = 4'h1,
      P_MON_OFFSET = 4'h2,
      P_PROX_A = 4'h3,
      P_PROX_B = 4'h4,
      P_NOTCH1_FREQ = 4'h5,
      P_NOTCH1_Q = 4'h6,
      P_NOTCH2_FREQ = 4'h7,
      P_NOTCH2_Q = 4'h8,
      P_SEQ_OPT = 4'h9,
      P_HOME_MODE = 4'ha,
      P_STOP_DECEL = 4'hb
   } param_id_type;

   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,
      H_SEEK = 4'b0010,
      H_INSIDE = 4'b0100,
      H_ZWAIT = 4'b1000
   } home_state_type;

   typedef enum logic [1:0] {
      S_IDLE = 2'b01,
      S_RUN = 2'b10
   } seq_state_type;

   typedef struct packed {
      logic [3:0] mon_sel;
      logic signed [31:0] mon_range;
      logic signed [31:0] mon_offset;
      logic [31:0] prox_a;
      logic [31:0] prox_b;
      logic [15:0] n1_freq;
      logic [15:0] n1_q;
      logic [15:0] n2_freq;
      logic [15:0] n2_q;
      logic n1_on;
      logic n2_on;
      logic [1:0] seq_opt;
      logic [2:0] home_mode;
      logic [15:0] stop_decel;
      logic [15:0] eff_decel;
      logic wr_err;
      logic [12:0] dc_volt;
      logic signed [15:0] mon_out;
      seq_state_type seq;
      logic [3:0] chan;
      logic chan_start;
      logic stop_pend;
      logic prog_halt;
      logic [7:0] force_mask;
      logic [7:0] force_val;
      logic [7:0] conn_out;
      logic [7:0] fbus_out;
      home_state_type home;
      logic home_move;
      logic home_rev;
      logic home_set;
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic [2:0] prev;
   } core_state_type;

endpackage

// file: include/proximity_if.sv
`timescale 1ns/1ps
`default_nettype none

interface proximity_if #(
   parameter int POS_W = 32
);
   logic signed [POS_W-1:0] position;
   logic signed [POS_W-1:0] target;
   logic [31:0] distance;
   logic active;
   logic near;

   modport cmp (
      input position,
      input target,
      input distance,
      input active,
      output near
   );

   modport core (
      output position,
      output target,
      output distance,
      output active,
      input near
   );
endinterface

`default_nettype wire

// file: hdl/proximity_cmp.sv
`timescale 1ns/1ps
`default_nettype none

module proximity_cmp #(
   parameter int POS_W = 32
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic nrst,
   // Comparison operands and result.
   proximity_if.cmp prox
);
   typedef struct packed {
      logic near;
   } prox_state_type;

   prox_state_type state_q;
   prox_state_type state_d;
   logic signed [POS_W:0] diff;
   logic [POS_W:0] mag;

   initial begin
      if (POS_W < 30 || POS_W > 62) begin
         $error("proximity_cmp: POS_W must lie in 30..62");
      end
   end

   always_comb begin
      diff = '0;
      mag = '0;
      state_d = state_q;
      diff = {prox.position[POS_W-1], prox.position} -
             {prox.target[POS_W-1], prox.target};
      mag = diff[POS_W] ? $unsigned(-diff) : $unsigned(diff);
      state_d.near = prox.active &&
                     (mag <= (POS_W+1)'(prox.distance));
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign prox.near = state_q.near;
endmodule

`default_nettype wire

// file: hdl/servo_param_monitor_home_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "servo_param_cfg.svh"

module servo_param_monitor_home_seq
   import servo_param_pkg::*;
#(
   parameter int POS_W = 32,
   parameter int CHAN_W = 4
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic nrst,
   // Parameter writes.
   input wire logic param_wr,
   input wire servo_param_pkg::param_id_type param_id,
   input wire logic [31:0] param_data,
   output logic param_wr_error,
   // Secondary analog monitor.
   input wire logic [8:0][15:0] monitor_items,
   output logic [3:0] secondary_monitor_select,
   output logic [31:0] secondary_monitor_range,
   output logic [31:0] secondary_monitor_offset,
   output logic [15:0] secondary_analog_out,
   // Bus voltage.
   input wire logic [11:0] dc_bus_raw,
   output logic [12:0] dc_bus_voltage_readout,
   // Positioning and proximity.
   input wire logic positioning_active,
   input wire logic [POS_W-1:0] motor_position,
   input wire logic [POS_W-1:0] target_position,
   output logic proximity_a_out,
   output logic proximity_b_out,
   // Notch filter settings.
   output logic [15:0] primary_notch_freq,
   output logic [15:0] primary_notch_quality,
   output logic primary_notch_on,
   output logic [15:0] secondary_notch_freq,
   output logic [15:0] secondary_notch_quality,
   output logic secondary_notch_on,
   // Program sequencing.
   input wire logic run_start,
   input wire logic [CHAN_W-1:0] channel_select_inputs,
   input wire logic channel_done,
   input wire logic line_busy,
   input wire logic motion_busy,
   input wire logic cycle_stop_cmd,
   output logic program_active,
   output logic [CHAN_W-1:0] program_channel,
   output logic channel_start,
   output logic program_halted,
   // Stop deceleration.
   input wire logic stop_request,
   input wire logic [15:0] move_decel,
   output logic [15:0] stop_decel_applied,
   // Forced outputs.
   input wire logic forced_output_cmd,
   input wire logic [7:0] forced_output_value,
   input wire logic [7:0] forced_output_keep,
   input wire logic forced_output_release,
   input wire logic [7:0] normal_outputs,
   output logic [7:0] control_io_connector,
   output logic [7:0] fieldbus_outputs,
   // Home return.
   input wire logic home_start,
   input wire logic home_sensor_pin,
   input wire logic limit_sensor_pin,
   input wire logic phase_z_pin,
   output logic [2:0] home_return_mode,
   output logic home_busy,
   output logic home_move,
   output logic home_reverse,
   output logic home_set
);
   import servo_param_pkg::*;

   core_state_type state_q;
   core_state_type state_d;
   logic [31:0] wr_val;
   logic wr_ok;
   logic [24:0] dc_prod;
   logic signed [16:0] mon_sum;
   logic hs_level;
   logic lim_level;
   logic z_rise;
   logic [CHAN_W-1:0] next_chan;

   proximity_if #(.POS_W(POS_W)) prox_a_link ();
   proximity_if #(.POS_W(POS_W)) prox_b_link ();

   initial begin
      if (CHAN_W < 1 || CHAN_W > 4) begin
         $error("servo_param_monitor_home_seq: CHAN_W must lie in 1..4");
      end
      if (POS_W < 30 || POS_W > 62) begin
         $error("servo_param_monitor_home_seq: POS_W must lie in 30..62");
      end
   end

   // ****************************************************************
   // Target proximity comparators.
   // ****************************************************************
   assign prox_a_link.position = motor_position;
   assign prox_a_link.target = target_position;
   assign prox_a_link.distance = state_q.prox_a;
   assign prox_a_link.active = positioning_active;
   assign prox_b_link.position = motor_position;
   assign prox_b_link.target = target_position;
   assign prox_b_link.distance = state_q.prox_b;
   assign prox_b_link.active = positioning_active;

   proximity_cmp #(.POS_W(POS_W)) prox_a_cmp (
      .core_clk(core_clk),
      .nrst(nrst),
      .prox(prox_a_link.cmp)
   );

   proximity_cmp #(.POS_W(POS_W)) prox_b_cmp (
      .core_clk(core_clk),
      .nrst(nrst),
      .prox(prox_b_link.cmp)
   );

   // ****************************************************************
   // Range check of a parameter write.
   // ****************************************************************
   always_comb begin
      wr_val = param_data;
      wr_ok = 1'b0;
      unique case (param_id)
         P_MON_SEL: wr_ok = wr_val <= `MON_SEL_MAX;
         P_MON_RANGE: wr_ok = $signed(wr_val) >= `MON_RANGE_MIN &&
                              $signed(wr_val) <= `MON_RANGE_MAX;
         P_MON_OFFSET: wr_ok = $signed(wr_val) >= -`MON_OFFSET_LIMIT &&
                               $signed(wr_val) <= `MON_OFFSET_LIMIT;
         P_PROX_A, P_PROX_B: wr_ok = wr_val <= `PROX_MAX;
         P_NOTCH1_FREQ, P_NOTCH2_FREQ: wr_ok = wr_val == 32'h0 ||
            (wr_val >= `NOTCH_FREQ_MIN && wr_val <= `NOTCH_FREQ_MAX);
         P_NOTCH1_Q, P_NOTCH2_Q: wr_ok = wr_val >= `NOTCH_Q_MIN &&
                                         wr_val <= `NOTCH_Q_MAX;
         P_SEQ_OPT: wr_ok = wr_val <= `SEQ_OPT_MAX;
         P_HOME_MODE: wr_ok = wr_val == 32'(`HOME_LEAVE) ||
                              wr_val == 32'(`HOME_LEAVE_Z) ||
                              wr_val == 32'(`HOME_ENTER_Z) ||
                              wr_val == 32'(`HOME_ENTER) ||
                              wr_val == 32'(`HOME_HERE) ||
                              wr_val == 32'(`HOME_LIMIT_Z);
         P_STOP_DECEL: wr_ok = wr_val <= `STOP_DECEL_MAX;
         default: wr_ok = 1'b0;
      endcase
   end

   assign hs_level = state_q.sync2[0];
   assign lim_level = state_q.sync2[1];
   assign z_rise = state_q.sync2[2] & ~state_q.prev[2];
   assign next_chan = state_q.chan[CHAN_W-1:0] + CHAN_W'(1);
   assign dc_prod = 25'(dc_bus_raw) * 25'(`DC_FULL_SCALE);
   assign mon_sum = 17'(signed'(monitor_items[state_q.mon_sel])) +
                    17'(signed'(state_q.mon_offset[15:0]));

   // ****************************************************************
   // Next state.
   // ****************************************************************
   always_comb begin
      state_d = state_q;
      state_d.wr_err = 1'b0;
      state_d.chan_start = 1'b0;
      state_d.prog_halt = 1'b0;
      state_d.home_set = 1'b0;

      // Parameter writes; a refused value leaves the setting alone.
      if (param_wr) begin
         if (!wr_ok) begin
            state_d.wr_err = 1'b1;
         end else begin
            unique case (param_id)
               P_MON_SEL: begin
                  state_d.mon_sel = wr_val[3:0];
                  if (wr_val[3:0] != state_q.mon_sel) begin
                     state_d.mon_range = `MON_RANGE_AUTO;
                     state_d.mon_offset = `MON_OFFSET_AUTO;
                  end
               end
               P_MON_RANGE: state_d.mon_range = wr_val;
               P_MON_OFFSET: state_d.mon_offset = wr_val;
               P_PROX_A: state_d.prox_a = wr_val;
               P_PROX_B: state_d.prox_b = wr_val;
               P_NOTCH1_FREQ: state_d.n1_freq = wr_val[15:0];
               P_NOTCH1_Q: state_d.n1_q = wr_val[15:0];
               P_NOTCH2_FREQ: state_d.n2_freq = wr_val[15:0];
               P_NOTCH2_Q: state_d.n2_q = wr_val[15:0];
               P_SEQ_OPT: state_d.seq_opt = wr_val[1:0];
               P_HOME_MODE: state_d.home_mode = wr_val[2:0];
               P_STOP_DECEL: state_d.stop_decel = wr_val[15:0];
               default: state_d.wr_err = 1'b1;
            endcase
         end
      end
      state_d.n1_on = state_q.n1_freq != 16'h0;
      state_d.n2_on = state_q.n2_freq != 16'h0;

      // Monitor output saturates to the sixteen-bit output code.
      if (mon_sum > 17'sh07fff) begin
         state_d.mon_out = 16'sh7fff;
      end else if (mon_sum < -17'sh08000) begin
         state_d.mon_out = -16'sh8000;
      end else begin
         state_d.mon_out = mon_sum[15:0];
      end

      // Bus voltage in tenths of a volt, clipped at full scale.
      state_d.dc_volt = dc_prod[24:`DC_RAW_SHIFT];
      if (dc_prod[24:`DC_RAW_SHIFT] > `DC_FULL_SCALE) begin
         state_d.dc_volt = `DC_FULL_SCALE;
      end

      // Stop deceleration: the larger of stop_decel and the move's own value.
      if (state_q.stop_decel > move_decel) begin
         state_d.eff_decel = state_q.stop_decel;
      end else begin
         state_d.eff_decel = move_decel;
      end

      // Forced outputs; a kept digit leaves that port as it was.
      if (forced_output_release) begin
         state_d.force_mask = 8'h00;
      end
      if (forced_output_cmd) begin
         for (int i = 0; i < 8; i++) begin
            if (!forced_output_keep[i]) begin
               state_d.force_mask[i] = 1'b1;
               state_d.force_val[i] = forced_output_value[i];
            end
         end
      end
      state_d.conn_out = (state_q.force_mask & state_q.force_val) |
                         (~state_q.force_mask & normal_outputs);
      state_d.fbus_out = state_d.conn_out;

      // Program sequencer.
      state_d.stop_pend = (state_q.stop_pend && state_q.seq == S_RUN) ||
                          cycle_stop_cmd;
      unique case (state_q.seq)
         S_IDLE: begin
            state_d.stop_pend = 1'b0;
            if (run_start) begin
               state_d.seq = S_RUN;
               state_d.chan_start = 1'b1;
               if (state_q.seq_opt == 2'h1) begin
                  state_d.chan = 4'(next_chan);
               end else begin
                  state_d.chan = 4'(channel_select_inputs);
               end
            end
         end
         S_RUN: begin
            if (state_q.stop_pend && !line_busy && !motion_busy) begin
               state_d.seq = S_IDLE;
               state_d.prog_halt = 1'b1;
               state_d.stop_pend = 1'b0;
            end else if (channel_done) begin
               if (state_q.seq_opt == 2'h2 && !state_q.stop_pend) begin
                  state_d.chan = 4'(next_chan);
                  state_d.chan_start = 1'b1;
               end else begin
                  state_d.seq = S_IDLE;
                  state_d.prog_halt = 1'b1;
                  state_d.stop_pend = 1'b0;
               end
            end
         end
      endcase

      // Sensor synchronisers: sync1 is read only by sync2.
      state_d.sync1 = {phase_z_pin, limit_sensor_pin, home_sensor_pin};
      state_d.sync2 = state_q.sync1;
      state_d.prev = state_q.sync2;

      // Home return.
      unique case (state_q.home)
         H_IDLE: begin
            if (home_start) begin
               if (state_q.home_mode == `HOME_HERE) begin
                  state_d.home_set = 1'b1;
               end else begin
                  state_d.home = H_SEEK;
                  state_d.home_move = 1'b1;
                  state_d.home_rev = 1'b0;
               end
            end
         end
         H_SEEK: begin
            if (state_q.home_mode == `HOME_LIMIT_Z) begin
               if (lim_level) begin
                  state_d.home_rev = 1'b1;
                  state_d.home = H_ZWAIT;
               end
            end else if (hs_level) begin
               if (state_q.home_mode == `HOME_ENTER) begin
                  state_d.home_set = 1'b1;
                  state_d.home_move = 1'b0;
                  state_d.home = H_IDLE;
               end else if (state_q.home_mode == `HOME_ENTER_Z) begin
                  state_d.home = H_ZWAIT;
               end else begin
                  state_d.home = H_INSIDE;
               end
            end
         end
         H_INSIDE: begin
            if (!hs_level) begin
               if (state_q.home_mode == `HOME_LEAVE) begin
                  state_d.home_set = 1'b1;
                  state_d.home_move = 1'b0;
                  state_d.home = H_IDLE;
               end else begin
                  state_d.home = H_ZWAIT;
               end
            end
         end
         H_ZWAIT: begin
            if (z_rise) begin
               state_d.home_set = 1'b1;
               state_d.home_move = 1'b0;
               state_d.home_rev = 1'b0;
               state_d.home = H_IDLE;
            end
         end
      endcase
      if (stop_request && state_q.home != H_IDLE) begin
         state_d.home = H_IDLE;
         state_d.home_move = 1'b0;
         state_d.home_rev = 1'b0;
         state_d.home_set = 1'b0;
      end
   end

   // ****************************************************************
   // State register.
   // ****************************************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= '0;
         state_q.mon_sel <= `MON_SEL_RESET;
         state_q.mon_range <= `MON_RANGE_RESET;
         state_q.mon_offset <= `MON_OFFSET_RESET;
         state_q.prox_a <= `PROX_RESET;
         state_q.prox_b <= `PROX_RESET;
         state_q.n1_freq <= `NOTCH_FREQ_RESET;
         state_q.n1_q <= `NOTCH_Q_RESET;
         state_q.n2_freq <= `NOTCH_FREQ_RESET;
         state_q.n2_q <= `NOTCH_Q_RESET;
         state_q.seq_opt <= `SEQ_OPT_RESET;
         state_q.home_mode <= `HOME_MODE_RESET;
         state_q.stop_decel <= `STOP_DECEL_RESET;
         state_q.seq <= S_IDLE;
         state_q.home <= H_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ****************************************************************
   // Outputs.
   // ****************************************************************
   assign param_wr_error = state_q.wr_err;
   assign secondary_monitor_select = state_q.mon_sel;
   assign secondary_monitor_range = state_q.mon_range;
   assign secondary_monitor_offset = state_q.mon_offset;
   assign secondary_analog_out = state_q.mon_out;
   assign dc_bus_voltage_readout = state_q.dc_volt;
   assign proximity_a_out = prox_a_link.near;
   assign proximity_b_out = prox_b_link.near;
   assign primary_notch_freq = state_q.n1_freq;
   assign primary_notch_quality = state_q.n1_q;
   assign primary_notch_on = state_q.n1_on;
   assign secondary_notch_freq = state_q.n2_freq;
   assign secondary_notch_quality = state_q.n2_q;
   assign secondary_notch_on = state_q.n2_on;
   assign program_active = state_q.seq == S_RUN;
   assign program_channel = state_q.chan[CHAN_W-1:0];
   assign channel_start = state_q.chan_start;
   assign program_halted = state_q.prog_halt;
   assign stop_decel_applied = state_q.eff_decel;
   assign control_io_connector = state_q.conn_out;
   assign fieldbus_outputs = state_q.fbus_out;
   assign home_return_mode = state_q.home_mode;
   assign home_busy = state_q.home != H_IDLE;
   assign home_move = state_q.home_move;
   assign home_reverse = state_q.home_rev;
   assign home_set = state_q.home_set;
endmodule

`default_nettype wire

// file: testbench/home_rig.sv
`timescale 1ns/1ps
`default_nettype none

// Sensor pattern of an axis that only advances while home_move is high.
module home_rig (
   input wire logic core_clk,
   input wire logic home_move,
   output logic home_sensor_pin,
   output logic limit_sensor_pin,
   output logic phase_z_pin
);
   logic [5:0] n = 6'h0;
   always @(posedge core_clk) n <= home_move ? n + 6'h1 : 6'h0;
   assign home_sensor_pin = n > 6'h4 && n < 6'h10;
   assign limit_sensor_pin = n > 6'h8;
   assign phase_z_pin = n[2:0] == 3'h7;
endmodule

`default_nettype wire

// file: testbench/servo_param_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module servo_param_chk
   import servo_param_pkg::*;
(
   input wire logic core_clk, nrst, param_wr, param_wr_error,
   input wire servo_param_pkg::param_id_type param_id,
   input wire logic [31:0] param_data, secondary_monitor_range,
   input wire logic [31:0] secondary_monitor_offset,
   input wire logic [3:0] secondary_monitor_select,
   input wire logic [12:0] dc_bus_voltage_readout,
   input wire logic [15:0] primary_notch_freq,
   input wire logic positioning_active, proximity_a_out, proximity_b_out,
   input wire logic primary_notch_on, run_start, program_active, home_set,
   input wire logic channel_start, home_start, home_busy, home_move,
   input wire logic [2:0] home_return_mode
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   sequence s_sel(ok);
      param_wr && param_id == P_MON_SEL && ok;
   endsequence
   sequence s_here;
      home_set && !home_move;
   endsequence
   a_sel_take: assert property (s_sel(param_data <= 8) |=>
      secondary_monitor_select == $past(param_data[3:0]))
      else $error("select not taken");
   a_sel_refuse: assert property (s_sel(param_data > 8) |=>
      param_wr_error && $stable(secondary_monitor_select))
      else $error("bad select kept");
   a_auto_reset: assert property (s_sel(param_data <= 8 &&
      param_data[3:0] != secondary_monitor_select) |=>
      secondary_monitor_range == 10000 && secondary_monitor_offset == 0)
      else $error("no auto reset");
   a_dc_span: assert property (dc_bus_voltage_readout <= 13'd4013)
      else $error("bus voltage span");
   a_prox_idle: assert property (!positioning_active |=>
      !proximity_a_out && !proximity_b_out) else $error("proximity idle");
   a_notch_lag: assert property (1'b1 |-> primary_notch_on ==
      ($past(primary_notch_freq) != 16'h0)) else $error("notch enable");
   a_run_start: assert property (run_start && !program_active |=>
      program_active && channel_start) else $error("run start");
   a_home_here: assert property (home_start && !home_busy &&
      home_return_mode == 3'h6 |=> s_here) else $error("home here");
endmodule

bind servo_param_monitor_home_seq servo_param_chk servo_param_chk_inst (.*);

`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CK(k, e, a) begin checks++; if ((a) !== (e)) begin err_total++; \
   $display("[ERR] item %0d exp %0h got %0h", k, e, a); end end

module tb;
   import servo_param_pkg::*;
   typedef struct {int k; logic [15:0] e;} note_type;
   logic core_clk = 0, nrst = 0, param_wr = 0, run_start = 0;
   logic channel_done = 0, line_busy = 0, motion_busy = 0;
   logic cycle_stop_cmd = 0, stop_request = 0, positioning_active = 0;
   logic forced_output_cmd = 0, forced_output_release = 0, home_start = 0;
   logic home_sensor_pin, limit_sensor_pin, phase_z_pin, param_wr_error;
   logic proximity_a_out, proximity_b_out, primary_notch_on, home_set;
   logic secondary_notch_on, program_active, channel_start, home_move;
   logic program_halted, home_busy, home_reverse;
   param_id_type param_id = P_MON_SEL;
   logic [31:0] param_data = '0, motor_position = '0, target_position = '0;
   logic [31:0] secondary_monitor_range, secondary_monitor_offset;
   logic [8:0][15:0] monitor_items = '0;
   logic [11:0] dc_bus_raw = '0;
   logic [12:0] dc_bus_voltage_readout;
   logic [3:0] channel_select_inputs = '0, secondary_monitor_select;
   logic [3:0] program_channel;
   logic [2:0] home_return_mode;
   logic [15:0] move_decel = '0, secondary_analog_out, stop_decel_applied;
   logic [15:0] primary_notch_freq, primary_notch_quality;
   logic [15:0] secondary_notch_freq, secondary_notch_quality;
   logic [7:0] forced_output_value = '0, forced_output_keep = '0;
   logic [7:0] normal_outputs = '0, control_io_connector, fieldbus_outputs;
   logic [15:0] o [13];
   int err_total = 0, checks = 0;
   int bad [12] = '{9, 0, 32768, 262144001, 262144001, 39, 9, 1001, 501,
      3, 2, 8001};
   int good [12] = '{8, 100000, 32767, 10, 3, 1000, 500, 40, 10, 2, 7, 100};
   int modes [6] = '{6, 5, 1, 4, 3, 7};
   note_type q[$], nt;
   event go;
   servo_param_monitor_home_seq servo_param_monitor_home_seq_inst (.*);
   home_rig home_rig_inst (.*);
   // Observed results, indexed by the key that each note carries.
   assign o = '{16'(secondary_monitor_select), secondary_monitor_range[15:0],
      secondary_monitor_offset[15:0], secondary_analog_out,
      16'(param_wr_error), 16'(dc_bus_voltage_readout),
      16'({proximity_a_out, proximity_b_out}),
      16'({program_active, channel_start, program_halted, program_channel}),
      {control_io_connector, fieldbus_outputs}, 16'({home_set, home_move}),
      primary_notch_quality, 16'(home_return_mode), stop_decel_applied};
   always #2.5 core_clk = ~core_clk;
   always @go begin
      while (q.size() > 0) begin
         nt = q.pop_front();
         `CK(nt.k, nt.e, o[nt.k])
      end
   end
   task automatic cyc(int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic pl(ref logic s);
      s = 1;
      cyc(1);
      s = 0;
   endtask
   task automatic wr(param_id_type i, logic [31:0] d);
      cyc(1);
      param_id = i;
      param_data = d;
      pl(param_wr);
   endtask
   task automatic ex(int k, logic [15:0] e);
      q.push_back('{k, e});
      ->go;
   endtask
   task report_and_stop();
      if (err_total == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #100000;
      err_total++;
      report_and_stop();
   end
   initial begin
      void'($urandom(3713));
      foreach (monitor_items[i]) monitor_items[i] = 16'($urandom() & 'hfff);
      cyc(4);
      nrst = 1;
      ex(1, 16'd10000);
      ex(10, 16'd25);
      ex(11, 16'h6);
      ex(0, 16'h0);
      wr(P_MON_OFFSET, 32'h7);
      wr(P_MON_SEL, 32'h3);
      ex(0, 16'h3);
      ex(2, 16'h0);
      wr(P_MON_OFFSET, 32'h5);
      cyc(1);
      ex(3, monitor_items[3] + 16'h5);
      wr(P_MON_OFFSET, -32'sd5);
      cyc(1);
      ex(3, monitor_items[3] - 16'h5);
      foreach (bad[i]) begin
         wr(param_id_type'(i), bad[i]);
         ex(4, 16'h1);
         wr(param_id_type'(i), good[i]);
         ex(4, 16'h0);
      end
      ex(10, 16'd500);
      cyc(1);
      ex(12, 16'd100);
      move_decel = 16'd300;
      positioning_active = 1;
      motor_position = 32'h64;
      target_position = 32'h6c;
      cyc(1);
      ex(12, 16'd300);
      ex(6, 16'h2);
      target_position = 32'h61;
      cyc(1);
      ex(6, 16'h3);
      repeat (3) begin
         dc_bus_raw = 12'($urandom());
         cyc(1);
         ex(5, 16'((32'(dc_bus_raw) * 4013) >> 12));
      end
      channel_select_inputs = 4'h2;
      pl(run_start);
      ex(7, 16'h62);
      pl(channel_done);
      ex(7, 16'h63);
      line_busy = 1;
      pl(cycle_stop_cmd);
      cyc(2);
      ex(7, 16'h43);
      line_busy = 0;
      cyc(1);
      ex(7, 16'h13);
      wr(P_SEQ_OPT, 32'h0);
      channel_select_inputs = 4'h5;
      pl(run_start);
      pl(channel_done);
      ex(7, 16'h15);
      wr(P_SEQ_OPT, 32'h1);
      channel_select_inputs = 4'h9;
      pl(run_start);
      ex(7, 16'h66);
      pl(channel_done);
      normal_outputs = 8'haa;
      forced_output_value = 8'h01;
      forced_output_keep = 8'hfe;
      pl(forced_output_cmd);
      cyc(1);
      ex(8, 16'habab);
      forced_output_value = 8'h00;
      forced_output_keep = 8'h7f;
      pl(forced_output_cmd);
      cyc(1);
      ex(8, 16'h2b2b);
      pl(forced_output_release);
      cyc(2);
      ex(8, 16'haaaa);
      foreach (modes[i]) begin
         wr(P_HOME_MODE, modes[i]);
         pl(home_start);
         for (int j = 0; j < 80 && home_set !== 1'b1; j++) cyc(1);
         ex(9, 16'h2);
      end
      report_and_stop();
   end
endmodule

`default_nettype wire
